// File: rtl/pap_top.sv
// Per-phase active power datapath and total-power combiner.
// Assumes high-pass filtered current samples on sys_clk;
// configuration inputs are held static by software.
`timescale 1ns/10ps
//
// Contract
// - Each phase multiplies its current sample by its voltage sample.
// - Each product is low-pass filtered; its dc part is the phase power.
// - Each phase has a signed 12-bit power offset.
// - One offset step weighs one step of the 28-bit power bus.
// - Offset is added to the phase power on every low-pass output.
// - Reverse flags for A, B, C sit in bits 12 to 14.
// - A flag reads 1 when its phase power is negative.
// - A deselected phase always shows a cleared reverse flag.
// - Phase A select is mode bit 5; it enables accumulation and detection.
// - Mode bits 7 and 6 choose the combination formula.
// - A set select bit includes its term, except B in modes 1 and 2; a cleared one gives zero.
// - Mode 0 sums all; mode 1 and 2 use B-differenced currents.
// - Products use high-pass filtered, gain corrected currents.
// - Current gain, then offset after multiply, then watt gain.
// - Gains are signed 12-bit; 800h smallest range, 7FFh largest.
// - Total power is delivered once every four clock periods while the buffer has room.
module pap_top
    import pap_pkg::*;
(
    // Clock and reset
    input  wire logic                        sys_clk,
    input  wire logic                        reset,
    // Sample inputs
    input  wire logic                        sample_valid,
    input  wire logic signed [SAMPLE_W-1:0]  volt_a,
    input  wire logic signed [SAMPLE_W-1:0]  volt_b,
    input  wire logic signed [SAMPLE_W-1:0]  volt_c,
    input  wire logic signed [SAMPLE_W-1:0]  curr_a,
    input  wire logic signed [SAMPLE_W-1:0]  curr_b,
    input  wire logic signed [SAMPLE_W-1:0]  curr_c,
    // Calibration settings
    input  wire logic signed [GAIN_W-1:0]    phase_a_current_gain,
    input  wire logic signed [GAIN_W-1:0]    phase_b_current_gain,
    input  wire logic signed [GAIN_W-1:0]    phase_c_current_gain,
    input  wire logic signed [GAIN_W-1:0]    phase_a_watt_gain,
    input  wire logic signed [GAIN_W-1:0]    phase_b_watt_gain,
    input  wire logic signed [GAIN_W-1:0]    phase_c_watt_gain,
    input  wire logic signed [OFFSET_W-1:0]  phase_a_power_offset,
    input  wire logic signed [OFFSET_W-1:0]  phase_b_power_offset,
    input  wire logic signed [OFFSET_W-1:0]  phase_c_power_offset,
    // Mode and numerator settings
    input  wire logic [MODE_W-1:0]           active_power_mode,
    input  wire logic [NUMER_W-1:0]          pulse_numerator,
    // Status read-back
    output logic [NUMSIGN_W-1:0]             pulse_numerator_and_sign,
    // Total power toward the energy accumulator
    output logic                             acc_valid,
    output logic [TOTAL_W-1:0]               acc_data,
    input  wire logic                        acc_ready
);

    // ==========================================================
    // Input gathering
    logic signed [SAMPLE_W-1:0] volt_in  [NPH];
    logic signed [SAMPLE_W-1:0] curr_in  [NPH];
    logic signed [GAIN_W-1:0]   cgain_in [NPH];
    logic signed [GAIN_W-1:0]   watt_gain_in [NPH];
    logic signed [OFFSET_W-1:0] ofs_in   [NPH];
    logic [NPH-1:0]             phase_select;
    logic [1:0]                 combination_mode;

    assign volt_in[0]  = volt_a;
    assign volt_in[1]  = volt_b;
    assign volt_in[2]  = volt_c;
    assign curr_in[0]  = curr_a;
    assign curr_in[1]  = curr_b;
    assign curr_in[2]  = curr_c;
    assign cgain_in[0] = phase_a_current_gain;
    assign cgain_in[1] = phase_b_current_gain;
    assign cgain_in[2] = phase_c_current_gain;
    assign watt_gain_in[0] = phase_a_watt_gain;
    assign watt_gain_in[1] = phase_b_watt_gain;
    assign watt_gain_in[2] = phase_c_watt_gain;
    assign ofs_in[0]   = phase_a_power_offset;
    assign ofs_in[1]   = phase_b_power_offset;
    assign ofs_in[2]   = phase_c_power_offset;

    assign phase_select[0]  = active_power_mode[SEL_A_BIT];
    assign phase_select[1]  = active_power_mode[SEL_B_BIT];
    assign phase_select[2]  = active_power_mode[SEL_C_BIT];
    assign combination_mode = active_power_mode[COMB_HI_BIT:COMB_LO_BIT];

    // ==========================================================
    // Pipeline state
    logic signed [CUR_W-1:0]    cur_reg   [NPH];
    logic signed [CUR_W-1:0]    cur_next  [NPH];
    logic signed [SAMPLE_W-1:0] volt_reg  [NPH];
    logic signed [SAMPLE_W-1:0] volt_next [NPH];
    logic                       s1_valid_reg, s1_valid_next;
    logic signed [POWER_W-1:0]  prod_reg  [NPH];
    logic signed [POWER_W-1:0]  prod_next [NPH];
    logic                       s2_valid_reg, s2_valid_next;
    logic signed [POWER_W-1:0]  lpf_out   [NPH];
    logic [NPH-1:0]             lpf_valid;
    logic signed [PHASE_W-1:0]  phase_reg  [NPH];
    logic signed [PHASE_W-1:0]  phase_next [NPH];
    logic signed [CUR_W-1:0]    cur_scaled [NPH];
    logic signed [DIFF_W-1:0]   cur_oper   [NPH];
    logic [NPH-1:0]             term_on;

    // ==========================================================
    // Per-phase datapath
    genvar p;
    generate
        for (p = 0; p < NPH; p++) begin : g_phase
            logic signed [SAMPLE_W+GAIN_W-1:0] cur_x_gain;
            logic signed [PROD_W-1:0]          product;
            logic signed [PHASE_W-1:0]         with_ofs;
            logic signed [PHASE_W+GAIN_W-1:0]  ofs_x_gain;

            // Current scaled by (1 + gain/2^12); signed gain gives the 800h..7FFh range
            assign cur_x_gain    = curr_in[p] * cgain_in[p];
            assign cur_scaled[p] = CUR_W'(curr_in[p]) + CUR_W'(cur_x_gain >>> GAIN_FRAC);

            // Instantaneous power as the full 50-bit product, shifted onto the 28-bit power bus
            assign product = volt_reg[p] * cur_oper[p];

            pap_lowpass u_lowpass (
                .sys_clk   (sys_clk),
                .reset     (reset),
                .in_valid  (s2_valid_reg),
                .in_data   (prod_reg[p]),
                .out_valid (lpf_valid[p]),
                .out_data  (lpf_out[p])
            );

            // Offset lands in bus LSBs, then watt gain scales the sum
            assign with_ofs   = PHASE_W'(lpf_out[p]) + PHASE_W'(ofs_in[p]);
            assign ofs_x_gain = with_ofs * watt_gain_in[p];

            always_comb begin
                cur_next[p]   = cur_reg[p];
                volt_next[p]  = volt_reg[p];
                prod_next[p]  = prod_reg[p];
                phase_next[p] = phase_reg[p];
                if (sample_valid) begin
                    cur_next[p]  = cur_scaled[p];
                    volt_next[p] = volt_in[p];
                end
                if (s1_valid_reg) begin
                    prod_next[p] = POWER_W'(product >>> PROD_SHIFT);
                end
                if (lpf_valid[p]) begin
                    phase_next[p] = with_ofs + PHASE_W'(ofs_x_gain >>> GAIN_FRAC);
                end
            end

            always_ff @(posedge sys_clk or posedge reset) begin
                if (reset) begin
                    cur_reg[p]   <= '0;
                    volt_reg[p]  <= '0;
                    prod_reg[p]  <= '0;
                    phase_reg[p] <= '0;
                end else begin
                    cur_reg[p]   <= cur_next[p];
                    volt_reg[p]  <= volt_next[p];
                    prod_reg[p]  <= prod_next[p];
                    phase_reg[p] <= phase_next[p];
                end
            end
        end
    endgenerate

    // ==========================================================
    // Current operands per combination mode
    // Reserved mode 3 falls back to the plain per-phase sum
    always_comb begin
        cur_oper[0] = DIFF_W'(cur_reg[0]);
        cur_oper[1] = DIFF_W'(cur_reg[1]);
        cur_oper[2] = DIFF_W'(cur_reg[2]);
        term_on     = phase_select;
        unique case (combination_mode)
            COMB_DIFF_AC: begin
                cur_oper[0] = DIFF_W'(cur_reg[0]) - DIFF_W'(cur_reg[1]);
                cur_oper[2] = DIFF_W'(cur_reg[2]) - DIFF_W'(cur_reg[1]);
                term_on[1]  = 1'b0;
            end
            COMB_DIFF_A: begin
                cur_oper[0] = DIFF_W'(cur_reg[0]) - DIFF_W'(cur_reg[1]);
                term_on[1]  = 1'b0;
            end
            COMB_SUM_ALL: begin
                term_on = phase_select;
            end
            default: begin
                term_on = phase_select;
            end
        endcase
    end

    // ==========================================================
    // Stage valids
    always_comb begin
        s1_valid_next = sample_valid;
        s2_valid_next = s1_valid_reg;
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            s1_valid_reg <= 1'b0;
            s2_valid_reg <= 1'b0;
        end else begin
            s1_valid_reg <= s1_valid_next;
            s2_valid_reg <= s2_valid_next;
        end
    end

    // ==========================================================
    // Total power and reverse-power flags
    logic signed [TOTAL_W-1:0] total_reg, total_next;
    logic [NPH-1:0]            reverse_reg, reverse_next;
    logic [NUMSIGN_W-1:0]      numsign_reg, numsign_next;

    always_comb begin
        total_next = '0;
        for (int k = 0; k < NPH; k++) begin
            if (term_on[k]) begin
                total_next = total_next + TOTAL_W'(phase_reg[k]);
            end
            // Sign of phase power, masked by its select bit
            reverse_next[k] = phase_reg[k][PHASE_W-1] & phase_select[k];
        end
        numsign_next                           = '0;
        numsign_next[NUMER_W-1:0]              = pulse_numerator;
        numsign_next[SIGN_C_BIT:SIGN_A_BIT]    = reverse_reg;
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            total_reg   <= '0;
            reverse_reg <= '0;
            numsign_reg <= '0;
        end else begin
            total_reg   <= total_next;
            reverse_reg <= reverse_next;
            numsign_reg <= numsign_next;
        end
    end

    assign pulse_numerator_and_sign = numsign_reg;

    // ==========================================================
    // Delivery every four clocks into the output buffer
    // A full buffer holds the tick, so no delivered word is ever dropped
    pap_stream_if #(.WIDTH(TOTAL_W)) deliver_if ();

    logic [1:0] tick_reg, tick_next;
    logic       push_reg, push_next;
    logic [TOTAL_W-1:0] word_reg, word_next;

    always_comb begin
        tick_next = tick_reg;
        push_next = push_reg;
        word_next = word_reg;
        if (push_reg && deliver_if.ready) begin
            push_next = 1'b0;
        end
        if (tick_reg == DELIVER_LAST) begin
            if (!push_reg || deliver_if.ready) begin
                tick_next = DELIVER_RESET;
                push_next = 1'b1;
                word_next = total_reg;
            end
        end else begin
            tick_next = tick_reg + 2'h1;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            tick_reg <= DELIVER_RESET;
            push_reg <= 1'b0;
            word_reg <= '0;
        end else begin
            tick_reg <= tick_next;
            push_reg <= push_next;
            word_reg <= word_next;
        end
    end

    assign deliver_if.valid = push_reg;
    assign deliver_if.data  = word_reg;

    pap_fifo #(.WIDTH(TOTAL_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .sys_clk   (sys_clk),
        .reset     (reset),
        .wr        (deliver_if.sink),
        .out_valid (acc_valid),
        .out_data  (acc_data),
        .out_ready (acc_ready)
    );

endmodule

// File: rtl/pap_pkg.sv
// Constants and field layouts for the polyphase active power datapath.
// Assumes a single master clock; configuration values arrive as static inputs.
package pap_pkg;

    // ==========================================================
    // Widths and arithmetic scaling
    localparam int SAMPLE_W   = 24;
    localparam int GAIN_W     = 12;
    localparam int GAIN_FRAC  = 12;
    localparam int OFFSET_W   = 12;
    localparam int CUR_W      = SAMPLE_W + 1;
    localparam int DIFF_W     = CUR_W + 1;
    localparam int PROD_W     = SAMPLE_W + DIFF_W;
    localparam int PROD_SHIFT = 22;
    localparam int POWER_W    = 28;
    localparam int LPF_SHIFT  = 8;
    localparam int PHASE_W    = POWER_W + 2;
    localparam int TOTAL_W    = PHASE_W + 2;
    localparam int NPH        = 3;

    // ==========================================================
    // Mode register fields
    localparam int MODE_W      = 8;
    localparam int SEL_A_BIT   = 5;
    localparam int SEL_B_BIT   = 4;
    localparam int SEL_C_BIT   = 3;
    localparam int COMB_LO_BIT = 6;
    localparam int COMB_HI_BIT = 7;
    localparam logic [1:0] COMB_SUM_ALL   = 2'h0;
    localparam logic [1:0] COMB_DIFF_AC   = 2'h1;
    localparam logic [1:0] COMB_DIFF_A    = 2'h2;

    // ==========================================================
    // Numerator and sign register fields
    localparam int NUMSIGN_W  = 16;
    localparam int NUMER_W    = 12;
    localparam int SIGN_A_BIT = 12;
    localparam int SIGN_C_BIT = 14;

    // ==========================================================
    // Delivery and buffering
    localparam int         FIFO_DEPTH     = 8;
    localparam int         DELIVER_CYCLES = 4;
    localparam logic [1:0] DELIVER_LAST   = 2'(DELIVER_CYCLES - 1);
    localparam logic [1:0] DELIVER_RESET  = 2'h0;

endpackage

// File: rtl/pap_stream_if.sv
// Valid/ready word stream between the datapath and its output buffer.
// Assumes both ends share one clock.
`timescale 1ns/10ps
interface pap_stream_if #(parameter int WIDTH = 32);
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] data;

    modport source (output valid, output data, input ready);
    modport sink   (input valid, input data, output ready);
endinterface

// File: rtl/pap_lowpass.sv
// First-order low-pass that keeps the dc part of one phase's power product.
// Assumes in_valid marks each new product on the shared clock.
`timescale 1ns/10ps
module pap_lowpass
    import pap_pkg::*;
(
    // Clock and reset
    input  wire logic                      sys_clk,
    input  wire logic                      reset,
    // Product in
    input  wire logic                      in_valid,
    input  wire logic signed [POWER_W-1:0] in_data,
    // Filtered power out
    output logic                           out_valid,
    output logic signed [POWER_W-1:0]      out_data
);
    localparam int ACC_W = POWER_W + LPF_SHIFT + 1;

    logic signed [ACC_W-1:0] acc_reg;
    logic signed [ACC_W-1:0] acc_next;
    logic                    valid_reg;
    logic                    valid_next;
    logic signed [ACC_W-1:0] err;

    // ==========================================================
    // Filter update
    // Fractional bits keep small products from stalling the filter
    always_comb begin
        err        = (ACC_W'(in_data) <<< LPF_SHIFT) - acc_reg;
        acc_next   = acc_reg;
        valid_next = in_valid;
        if (in_valid) begin
            acc_next = acc_reg + (err >>> LPF_SHIFT);
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            acc_reg   <= '0;
            valid_reg <= 1'b0;
        end else begin
            acc_reg   <= acc_next;
            valid_reg <= valid_next;
        end
    end

    assign out_valid = valid_reg;
    assign out_data  = POWER_W'(acc_reg >>> LPF_SHIFT);
endmodule

// File: rtl/pap_fifo.sv
// Word FIFO with a registered output stage.
// Assumes DEPTH is a power of two; the drain side may stall at will.
`timescale 1ns/10ps
module pap_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             reset,
    // Fill side
    pap_stream_if.sink            wr,
    // Drain side
    output logic                  out_valid,
    output logic [WIDTH-1:0]      out_data,
    input  wire logic             out_ready
);
    localparam int PTR_W = $clog2(DEPTH);
    localparam int CNT_W = $clog2(DEPTH + 1);
    localparam logic [CNT_W-1:0] FULL_COUNT = CNT_W'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr_reg, wr_ptr_next;
    logic [PTR_W-1:0] rd_ptr_reg, rd_ptr_next;
    logic [CNT_W-1:0] count_reg, count_next;
    logic             oval_reg, oval_next;
    logic [WIDTH-1:0] odata_reg, odata_next;
    logic             push;
    logic             pop;

    // ==========================================================
    // Pointer and count control
    assign wr.ready = (count_reg != FULL_COUNT);
    assign push     = wr.valid && wr.ready;
    assign pop      = (count_reg != '0) && (!oval_reg || out_ready);

    always_comb begin
        wr_ptr_next = wr_ptr_reg;
        rd_ptr_next = rd_ptr_reg;
        count_next  = count_reg;
        oval_next   = oval_reg;
        odata_next  = odata_reg;
        if (push) begin
            wr_ptr_next = wr_ptr_reg + 1'b1;
        end
        if (pop) begin
            rd_ptr_next = rd_ptr_reg + 1'b1;
            odata_next  = mem[rd_ptr_reg];
            oval_next   = 1'b1;
        end else if (out_ready) begin
            oval_next = 1'b0;
        end
        if (push && !pop) begin
            count_next = count_reg + 1'b1;
        end else if (pop && !push) begin
            count_next = count_reg - 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= wr.data;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
            oval_reg   <= 1'b0;
            odata_reg  <= '0;
        end else begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            count_reg  <= count_next;
            oval_reg   <= oval_next;
            odata_reg  <= odata_next;
        end
    end

    assign out_valid = oval_reg;
    assign out_data  = odata_reg;
endmodule

// File: verif/pap_top_props.sv
// Checker for the active power datapath, watching only the top ports.
// Assumes configuration inputs are held static between changes.
`timescale 1ns/10ps
module pap_top_props
    import pap_pkg::*;
(
    input wire logic                 sys_clk,
    input wire logic                 reset,
    input wire logic [MODE_W-1:0]    active_power_mode,
    input wire logic [NUMER_W-1:0]   pulse_numerator,
    input wire logic [NUMSIGN_W-1:0] pulse_numerator_and_sign,
    input wire logic                 acc_valid,
    input wire logic [TOTAL_W-1:0]   acc_data,
    input wire logic                 acc_ready
);
    // ==========================================================
    // Cycles each select bit has been clear, saturating at 8 to cover pipeline lag
    logic [3:0] off_reg  [NPH];
    logic [3:0] off_next [NPH];
    always_comb begin
        for (int k = 0; k < NPH; k++) begin
            off_next[k] = active_power_mode[SEL_A_BIT-k] ? 4'h0 : off_reg[k] + {3'h0, off_reg[k] != 4'h8};
        end
    end
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            off_reg <= '{default: 4'h0};
        end else begin
            off_reg <= off_next;
        end
    end
    // ==========================================================
    // Properties
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    property p_quiet;
        $past(reset) |-> (!acc_valid && pulse_numerator_and_sign[14:12] == 3'h0) [*4];
    endproperty
    property p_first;
        $past(reset) |-> ##[4:12] acc_valid;
    endproperty
    property p_hold;
        acc_valid && !acc_ready |=> acc_valid && $stable(acc_data);
    endproperty
    property p_drop;
        $fell(acc_valid) |-> $past(acc_ready);
    endproperty
    property p_top;
        pulse_numerator_and_sign[NUMSIGN_W-1] == 1'b0;
    endproperty
    property p_numer;
        !$past(reset) |-> pulse_numerator_and_sign[NUMER_W-1:0] == $past(pulse_numerator);
    endproperty
    property p_desel_a;
        off_reg[0] == 4'h8 |-> !pulse_numerator_and_sign[SIGN_A_BIT];
    endproperty
    property p_desel_bc;
        (off_reg[1] == 4'h8 |-> !pulse_numerator_and_sign[13]) and
        (off_reg[2] == 4'h8 |-> !pulse_numerator_and_sign[SIGN_C_BIT]);
    endproperty
    a_quiet: assert property (p_quiet) else $error("output active right after reset");
    a_first: assert property (p_first) else $error("no delivery after reset");
    a_hold: assert property (p_hold) else $error("word changed while stalled");
    a_drop: assert property (p_drop) else $error("word dropped without take");
    a_top: assert property (p_top) else $error("status top bit set");
    a_numer: assert property (p_numer) else $error("numerator echo wrong");
    a_desel_a: assert property (p_desel_a) else $error("A flag while deselected");
    a_desel_bc: assert property (p_desel_bc) else $error("B or C flag while deselected");
    c_take: cover property (acc_valid && acc_ready);
    c_stall: cover property ((acc_valid && !acc_ready) [*4]);
    c_flag: cover property (pulse_numerator_and_sign[SIGN_A_BIT]);
endmodule
bind pap_top pap_top_props u_props (.sys_clk, .reset, .active_power_mode, .pulse_numerator,
    .pulse_numerator_and_sign, .acc_valid, .acc_data, .acc_ready);

// File: verif/pap_acc_model.sv
// Energy accumulator model: takes total power words, stalling on request.
// Assumes stall is driven by non-blocking assignment at the falling edge.
`timescale 1ns/10ps
module pap_acc_model
    import pap_pkg::*;
(
    input wire logic               sys_clk,
    input wire logic               reset,
    input wire logic               stall,
    input wire logic               acc_valid,
    input wire logic [TOTAL_W-1:0] acc_data,
    output logic                   acc_ready,
    output logic [TOTAL_W-1:0]     last_word,
    output int                     takes,
    output int                     gap
);
    int since;
    // Ready moves off the sampling edge so a take is never ambiguous
    always @(negedge sys_clk) acc_ready <= !stall && !reset;
    always @(posedge sys_clk) begin
        since <= since + 1;
        if (acc_valid && acc_ready) begin
            last_word <= acc_data;
            takes <= takes + 1;
            gap <= since + 1;
            since <= 0;
        end
    end
endmodule

// File: verif/polyphase_active_power_tb.sv
// Self-checking bench for the active power datapath and combiner.
// Assumes the accumulator model and bound checker run beside it.
`timescale 1ns/10ps
module polyphase_active_power_tb
    import pap_pkg::*;
();
    logic                       sys_clk = 1'b0;
    logic                       reset = 1'b1;
    logic                       sample_valid = 1'b0;
    logic                       stall = 1'b0;
    logic signed [SAMPLE_W-1:0] volt [NPH] = '{default: '0};
    logic signed [SAMPLE_W-1:0] curr [NPH] = '{default: '0};
    logic signed [GAIN_W-1:0]   cgain [NPH] = '{default: '0};
    logic signed [GAIN_W-1:0]   watt_gain [NPH] = '{default: '0};
    logic signed [OFFSET_W-1:0] ofs [NPH] = '{default: '0};
    logic [MODE_W-1:0]          mode = 8'h00;
    logic [NUMER_W-1:0]         numer = 12'h000;
    logic [NUMSIGN_W-1:0]       numsign;
    logic                       acc_valid, acc_ready;
    logic [TOTAL_W-1:0]         acc_data;
    logic [TOTAL_W-1:0]         last_word;
    int                         takes, gap, t0;
    int                         failures = 0;
    int                         checked = 0;
    logic [7:0]                 mode_tab [5] = '{8'h38, 8'h68, 8'ha8, 8'h30, 8'hf8};

    always #20 sys_clk = ~sys_clk;

    pap_top uut (.sys_clk, .reset, .sample_valid,
        .volt_a(volt[0]), .volt_b(volt[1]), .volt_c(volt[2]), .curr_a(curr[0]), .curr_b(curr[1]), .curr_c(curr[2]),
        .phase_a_current_gain(cgain[0]), .phase_b_current_gain(cgain[1]), .phase_c_current_gain(cgain[2]),
        .phase_a_watt_gain(watt_gain[0]), .phase_b_watt_gain(watt_gain[1]), .phase_c_watt_gain(watt_gain[2]),
        .phase_a_power_offset(ofs[0]), .phase_b_power_offset(ofs[1]), .phase_c_power_offset(ofs[2]),
        .active_power_mode(mode), .pulse_numerator(numer), .pulse_numerator_and_sign(numsign),
        .acc_valid, .acc_data, .acc_ready);
    pap_acc_model u_acc (.sys_clk, .reset, .stall, .acc_valid, .acc_data, .acc_ready, .last_word, .takes, .gap);

    // ==========================================================
    // Helpers
    task automatic stop_test();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input string name, input longint exp, input logic signed [TOTAL_W-1:0] got, input int tol);
        longint d;
        checked++;
        d = longint'(got) - exp;
        if ($isunknown(got) || d > tol || d < -tol) begin
            failures++;
            $display("mismatch %s expected %0d seen %0d", name, exp, got);
        end
    endtask
    task automatic wait_takes(input int n);
        int s;
        s = takes;
        for (int i = 0; i < 400 && takes < s + n; i++) @(negedge sys_clk);
        if (takes < s + n) begin
            failures++;
            $display("mismatch takes expected %0d seen %0d", s + n, takes);
            stop_test();
        end
    endtask
    task automatic do_reset();
        reset = 1'b1;
        repeat (4) @(negedge sys_clk);
        reset = 1'b0;
    endtask
    // Expected power of one phase; the low-pass settles to within an LSB
    function automatic longint ph_exp(longint v, longint op, longint o, longint wg);
        longint w;
        w = ((v * op) >>> PROD_SHIFT) + o;
        return w + ((w * wg) >>> GAIN_FRAC);
    endfunction
    task automatic check_cfg();
        longint     ip [NPH];
        longint     ph [NPH];
        longint     tot;
        logic [1:0] md;
        logic [2:0] fl, m;
        logic       dif;
        md = mode[COMB_HI_BIT:COMB_LO_BIT];
        tot = 0;
        for (int k = 0; k < NPH; k++) ip[k] = curr[k] + ((longint'(curr[k]) * cgain[k]) >>> GAIN_FRAC);
        for (int k = 0; k < NPH; k++) begin
            dif = ^md && (k == 0 || (k == 2 && md == 2'h1));
            ph[k] = ph_exp(volt[k], dif ? ip[k] - ip[1] : ip[k], ofs[k], watt_gain[k]);
            if (mode[SEL_A_BIT-k] && !(k == 1 && ^md)) tot += ph[k];
            fl[k] = mode[SEL_A_BIT-k] && ph[k] < 0;
            m[k] = ph[k] > 16 || ph[k] < -16;
        end
        chk("total", tot, last_word, 8);
        chk("flags", fl & m, numsign[14:12] & m, 0);
        chk("numer", numer, numsign[NUMER_W-1:0], 0);
        chk("gap", DELIVER_CYCLES, gap, 0);
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        void'($urandom(32'h5db101e5));
        do_reset();
        for (int n = 0; n < 8; n++) begin
            @(negedge sys_clk);
            for (int k = 0; k < NPH; k++) begin
                volt[k] = (n == 0) ? '0 : SAMPLE_W'($signed($urandom) >>> 9);
                curr[k] = (n == 0) ? '0 : SAMPLE_W'($signed($urandom) >>> 9);
                cgain[k] = (n < 3) ? 12'h000 : (n == 3) ? 12'h800 : (n == 4) ? 12'h7ff : GAIN_W'($urandom);
                watt_gain[k] = (n == 3) ? 12'h800 : (n == 4) ? 12'h7ff : GAIN_W'($urandom);
                ofs[k] = OFFSET_W'($urandom);
            end
            mode = (n < 5) ? mode_tab[n] : MODE_W'($urandom) & 8'hf8;
            numer = NUMER_W'($urandom);
            repeat (8000) begin
                @(negedge sys_clk);
                sample_valid = ($urandom % 8) != 0;
                stall <= ($urandom % 4) == 0;
            end
            @(negedge sys_clk) stall <= 1'b0;
            wait_takes(16);
            check_cfg();
        end
        // Back-pressure fills the buffer; release drains it in a burst
        stall <= 1'b1;
        repeat (4) @(negedge sys_clk);
        t0 = takes;
        repeat (80) @(negedge sys_clk);
        chk("stalled takes", t0, takes, 0);
        stall <= 1'b0;
        repeat (10) @(negedge sys_clk);
        chk("burst takes", 9, takes - t0, 0);
        do_reset();
        wait_takes(3);
        chk("gap after reset", DELIVER_CYCLES, gap, 0);
        stop_test();
    end
endmodule
